// ### hdl/cbm_exec.sv
// Block-move engine, flag unit, save cost and branch decoder behind an APB slave
//
// Overview of operation
// - Byte form: while 8-bit count nonzero copy source byte to destination, then stop.
// - Each byte bumps both pointers, drops count by one; cost is 4+2n states.
// - Word form uses the 16-bit count with the same copy loop until zero.
// - State costs assume on-chip memory; wait states are counted separately.
// - One extra state is charged when the extended control register is valid; here only the save/restore cost gets it, not the move cost.
// - Multi-register save or restore costs 7, 9 or 11 states for 2, 3, 4.
// - Word arithmetic sets half-carry on carry or borrow out of bit 11.
// - Longword arithmetic sets half-carry on carry or borrow out of bit 27.
// - Extended add or subtract keeps zero flag on zero result, else clears it.
// - Signed divide sets a flag when the divisor is negative, else clears it.
// - Signed divide sets negative flag when the quotient is negative, else clears.
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none

module cbm_exec #(
  parameter int ADDR_W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire cbm_pkg::cbm_apb_req_t apb_req,
  output cbm_pkg::cbm_apb_rsp_t apb_rsp,
  output cbm_pkg::cbm_mem_req_t mem_req,
  input wire cbm_pkg::cbm_mem_rsp_t mem_rsp
);
  import cbm_pkg::*;

  if (ADDR_W != 32) begin : g_addr_check
    $error("cbm_exec: ADDR_W must be 32");
  end

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic setup_rd;
  logic acc_wr;
  logic mapped;
  assign setup_rd = apb_req.psel && !apb_req.penable;
  assign acc_wr = apb_req.psel && apb_req.penable && apb_req.pwrite && mapped;
  assign mapped = (apb_req.paddr[1:0] == 2'b00) && (apb_req.paddr <= CBM_OFF_BRRES);

  logic wr_ctrl, wr_src, wr_dst, wr_count, wr_opa, wr_opb, wr_opsel, wr_flags;
  logic wr_save, wr_brop;
  assign wr_ctrl = acc_wr && (apb_req.paddr == CBM_OFF_CTRL);
  assign wr_src = acc_wr && (apb_req.paddr == CBM_OFF_SRC);
  assign wr_dst = acc_wr && (apb_req.paddr == CBM_OFF_DST);
  assign wr_count = acc_wr && (apb_req.paddr == CBM_OFF_COUNT);
  assign wr_opa = acc_wr && (apb_req.paddr == CBM_OFF_OPA);
  assign wr_opb = acc_wr && (apb_req.paddr == CBM_OFF_OPB);
  assign wr_opsel = acc_wr && (apb_req.paddr == CBM_OFF_OPSEL);
  assign wr_flags = acc_wr && (apb_req.paddr == CBM_OFF_FLAGS);
  assign wr_save = acc_wr && (apb_req.paddr == CBM_OFF_SAVE);
  assign wr_brop = acc_wr && (apb_req.paddr == CBM_OFF_BROP);

  // ---------------------------------------------------------------
  // Block-move engine
  // ---------------------------------------------------------------
  cbm_state_t state_reg;
  logic word_mode_reg, ext_valid_reg, done_reg;
  logic [31:0] src_reg, dst_reg, states_reg, stalls_reg;
  logic [15:0] count_reg;
  logic [7:0] byte_reg;
  logic [15:0] cnt_cur;
  logic busy;
  logic start;

  assign busy = (state_reg != CBM_ST_IDLE);
  assign start = wr_ctrl && apb_req.pwdata[CBM_CTRL_START] && !busy;
  // Byte form only looks at the low count byte; the high byte is left as is
  assign cnt_cur = word_mode_reg ? count_reg : {8'h00, count_reg[7:0]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= CBM_ST_IDLE;
    end else begin
      case (state_reg)
        CBM_ST_IDLE: begin
          if (start) begin
            state_reg <= CBM_ST_CHECK;
          end
        end
        CBM_ST_CHECK: begin
          state_reg <= (cnt_cur == 16'h0000) ? CBM_ST_IDLE : CBM_ST_READ;
        end
        CBM_ST_READ: begin
          if (mem_rsp.ready) begin
            state_reg <= CBM_ST_WRITE;
          end
        end
        CBM_ST_WRITE: begin
          if (mem_rsp.ready) begin
            state_reg <= (cnt_cur == 16'h0001) ? CBM_ST_IDLE : CBM_ST_READ;
          end
        end
        default: begin
          state_reg <= CBM_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_mode_reg <= 1'b0;
      ext_valid_reg <= 1'b0;
    end else if (wr_ctrl && !busy) begin
      word_mode_reg <= apb_req.pwdata[CBM_CTRL_WORD];
      ext_valid_reg <= apb_req.pwdata[CBM_CTRL_EXT];
    end
  end

  logic move_step;
  assign move_step = (state_reg == CBM_ST_WRITE) && mem_rsp.ready;

  // Software writes to pointers and count are ignored while a move runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_reg <= CBM_RST_WORD;
      dst_reg <= CBM_RST_WORD;
      count_reg <= CBM_RST_WORD[15:0];
    end else if (move_step) begin
      src_reg <= src_reg + 32'h0000_0001;
      dst_reg <= dst_reg + 32'h0000_0001;
      if (word_mode_reg) begin
        count_reg <= count_reg - 16'h0001;
      end else begin
        count_reg[7:0] <= count_reg[7:0] - 8'h01;
      end
    end else if (!busy) begin
      if (wr_src) begin
        src_reg <= apb_req.pwdata;
      end
      if (wr_dst) begin
        dst_reg <= apb_req.pwdata;
      end
      if (wr_count) begin
        count_reg <= apb_req.pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_reg <= 8'h00;
    end else if ((state_reg == CBM_ST_READ) && mem_rsp.ready) begin
      byte_reg <= mem_rsp.rdata;
    end
  end

  // Ideal cost excludes waits so software can compare against the on-chip figure
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      states_reg <= CBM_RST_WORD;
      stalls_reg <= CBM_RST_WORD;
    end else if (start) begin
      states_reg <= CBM_MOVE_BASE_STATES;
      stalls_reg <= CBM_RST_WORD;
    end else begin
      if (move_step) begin
        states_reg <= states_reg + CBM_MOVE_BYTE_STATES;
      end
      if (mem_req.req && !mem_rsp.ready) begin
        stalls_reg <= stalls_reg + 32'h0000_0001;
      end
    end
  end

  logic move_end;
  assign move_end = ((state_reg == CBM_ST_CHECK) && (cnt_cur == 16'h0000)) ||
                    (move_step && (cnt_cur == 16'h0001));

  // Completion sets done; only a new start clears it, and start needs idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
    end else if (move_end) begin
      done_reg <= 1'b1;
    end else if (start) begin
      done_reg <= 1'b0;
    end
  end

  assign mem_req.req = (state_reg == CBM_ST_READ) || (state_reg == CBM_ST_WRITE);
  assign mem_req.we = (state_reg == CBM_ST_WRITE);
  assign mem_req.addr = (state_reg == CBM_ST_WRITE) ? dst_reg : src_reg;
  assign mem_req.wdata = byte_reg;

  // ---------------------------------------------------------------
  // Flag unit
  // ---------------------------------------------------------------
  logic [31:0] opa_reg, opb_reg, result_reg;
  logic [15:0] flags_reg;
  logic [15:0] flags_next;
  logic [31:0] result_next;
  cbm_op_t op;
  assign op = cbm_op_t'(apb_req.pwdata[2:0]);

  always_comb begin
    logic [16:0] w;
    logic [12:0] wh;
    logic [32:0] l;
    logic [28:0] lh;
    logic [8:0] x;
    logic [7:0] ma, mb;
    logic [15:0] mdv;
    logic cin;
    w = 17'h00000;
    wh = 13'h0000;
    l = 33'h0_0000_0000;
    lh = 29'h0000_0000;
    x = 9'h000;
    ma = 8'h00;
    mb = 8'h00;
    mdv = 16'h0000;
    cin = flags_reg[CBM_FLG_C];
    flags_next = flags_reg;
    result_next = result_reg;
    case (op)
      CBM_OP_ADDW, CBM_OP_SUBW: begin
        if (op == CBM_OP_ADDW) begin
          w = {1'b0, opa_reg[15:0]} + {1'b0, opb_reg[15:0]};
          wh = {1'b0, opa_reg[11:0]} + {1'b0, opb_reg[11:0]};
          flags_next[CBM_FLG_V] = (opa_reg[15] == opb_reg[15]) && (w[15] != opa_reg[15]);
        end else begin
          w = {1'b0, opa_reg[15:0]} - {1'b0, opb_reg[15:0]};
          wh = {1'b0, opa_reg[11:0]} - {1'b0, opb_reg[11:0]};
          flags_next[CBM_FLG_V] = (opa_reg[15] != opb_reg[15]) && (w[15] != opa_reg[15]);
        end
        flags_next[CBM_FLG_H] = wh[12];
        flags_next[CBM_FLG_C] = w[16];
        flags_next[CBM_FLG_N] = w[15];
        flags_next[CBM_FLG_Z] = (w[15:0] == 16'h0000);
        result_next = {16'h0000, w[15:0]};
      end
      CBM_OP_ADDL, CBM_OP_SUBL: begin
        if (op == CBM_OP_ADDL) begin
          l = {1'b0, opa_reg} + {1'b0, opb_reg};
          lh = {1'b0, opa_reg[27:0]} + {1'b0, opb_reg[27:0]};
          flags_next[CBM_FLG_V] = (opa_reg[31] == opb_reg[31]) && (l[31] != opa_reg[31]);
        end else begin
          l = {1'b0, opa_reg} - {1'b0, opb_reg};
          lh = {1'b0, opa_reg[27:0]} - {1'b0, opb_reg[27:0]};
          flags_next[CBM_FLG_V] = (opa_reg[31] != opb_reg[31]) && (l[31] != opa_reg[31]);
        end
        flags_next[CBM_FLG_H] = lh[28];
        flags_next[CBM_FLG_C] = l[32];
        flags_next[CBM_FLG_N] = l[31];
        flags_next[CBM_FLG_Z] = (l[31:0] == 32'h0000_0000);
        result_next = l[31:0];
      end
      CBM_OP_ADDX, CBM_OP_SUBX: begin
        if (op == CBM_OP_ADDX) begin
          x = {1'b0, opa_reg[7:0]} + {1'b0, opb_reg[7:0]} + {8'h00, cin};
        end else begin
          x = {1'b0, opa_reg[7:0]} - {1'b0, opb_reg[7:0]} - {8'h00, cin};
        end
        flags_next[CBM_FLG_C] = x[8];
        flags_next[CBM_FLG_N] = x[7];
        // Zero only survives so a chain of extended ops tests the whole wide value
        if (x[7:0] != 8'h00) begin
          flags_next[CBM_FLG_Z] = 1'b0;
        end
        result_next = {24'h000000, x[7:0]};
      end
      CBM_OP_DIVXS: begin
        // Only the signs are produced; the quotient itself is not computed here
        ma = opb_reg[7] ? (8'h00 - opb_reg[7:0]) : opb_reg[7:0];
        mdv = opa_reg[15] ? (16'h0000 - opa_reg[15:0]) : opa_reg[15:0];
        mb = ma;
        flags_next[CBM_FLG_DVN] = opb_reg[7];
        flags_next[CBM_FLG_N] = (opa_reg[15] != opb_reg[7]) && (mb != 8'h00) &&
                                (mdv >= {8'h00, mb});
        result_next = result_reg;
      end
      default: begin
        flags_next = flags_reg;
        result_next = result_reg;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opa_reg <= CBM_RST_WORD;
      opb_reg <= CBM_RST_WORD;
    end else begin
      if (wr_opa) begin
        opa_reg <= apb_req.pwdata;
      end
      if (wr_opb) begin
        opb_reg <= apb_req.pwdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= CBM_RST_FLAGS;
      result_reg <= CBM_RST_WORD;
    end else if (wr_opsel) begin
      flags_reg <= flags_next;
      result_reg <= result_next;
    end else if (wr_flags) begin
      flags_reg <= apb_req.pwdata[15:0];
    end
  end

  // ---------------------------------------------------------------
  // Save/restore cost
  // ---------------------------------------------------------------
  logic [2:0] save_n_reg;
  logic [4:0] save_cost;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      save_n_reg <= CBM_RST_SAVE;
    end else if (wr_save) begin
      save_n_reg <= apb_req.pwdata[2:0];
    end
  end

  // Counts other than 2..4 cost zero to flag them as unsupported
  always_comb begin
    case (save_n_reg)
      3'h2: save_cost = CBM_SAVE2_STATES;
      3'h3: save_cost = CBM_SAVE3_STATES;
      3'h4: save_cost = CBM_SAVE4_STATES;
      default: save_cost = 5'h00;
    endcase
  end

  logic [4:0] save_total;
  assign save_total = (ext_valid_reg && (save_cost != 5'h00)) ?
                      (save_cost + CBM_EXT_EXTRA) : save_cost;

  // ---------------------------------------------------------------
  // Branch decoder
  // ---------------------------------------------------------------
  logic [31:0] brop_reg;
  logic [31:0] brres;
  logic [3:0] br_cond;
  logic br_short, br_long, br_take;
  logic [15:0] br_disp;
  logic fc, fv, fz, fn;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brop_reg <= CBM_RST_WORD;
    end else if (wr_brop) begin
      brop_reg <= apb_req.pwdata;
    end
  end

  assign fc = flags_reg[CBM_FLG_C];
  assign fv = flags_reg[CBM_FLG_V];
  assign fz = flags_reg[CBM_FLG_Z];
  assign fn = flags_reg[CBM_FLG_N];
  // Opcode bytes sit first byte in [31:24]
  assign br_short = (brop_reg[31:28] == CBM_BR_SHORT_HI);
  assign br_long = (brop_reg[31:24] == CBM_BR_LONG_OP) && (brop_reg[19:16] == 4'h0);
  assign br_cond = br_short ? brop_reg[27:24] : brop_reg[23:20];
  assign br_disp = br_short ? {{8{brop_reg[23]}}, brop_reg[23:16]} : brop_reg[15:0];

  always_comb begin
    case (br_cond)
      4'h0: br_take = 1'b1;
      4'h1: br_take = 1'b0;
      4'h2: br_take = !(fc || fz);
      4'h3: br_take = fc || fz;
      4'h4: br_take = !fc;
      4'h5: br_take = fc;
      4'h6: br_take = !fz;
      4'h7: br_take = fz;
      4'h8: br_take = !fv;
      4'h9: br_take = fv;
      4'ha: br_take = !fn;
      4'hb: br_take = fn;
      4'hc: br_take = (fn == fv);
      4'hd: br_take = (fn != fv);
      4'he: br_take = !fz && (fn == fv);
      default: br_take = fz || (fn != fv);
    endcase
  end

  assign brres = {br_disp, 6'h00, (br_short || br_long), br_take && (br_short || br_long),
                  br_cond, 1'b0, br_short ? CBM_BR_SHORT_LEN :
                  (br_long ? CBM_BR_LONG_LEN : 3'h0)};

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [31:0] prdata_reg;
  logic [31:0] rd_mux;
  always_comb begin
    case (apb_req.paddr)
      CBM_OFF_CTRL: rd_mux = {29'h0, ext_valid_reg, word_mode_reg, 1'b0};
      CBM_OFF_STATUS: rd_mux = {30'h0, done_reg, busy};
      CBM_OFF_SRC: rd_mux = src_reg;
      CBM_OFF_DST: rd_mux = dst_reg;
      CBM_OFF_COUNT: rd_mux = {16'h0000, count_reg};
      CBM_OFF_STATES: rd_mux = states_reg;
      CBM_OFF_STALLS: rd_mux = stalls_reg;
      CBM_OFF_OPA: rd_mux = opa_reg;
      CBM_OFF_OPB: rd_mux = opb_reg;
      CBM_OFF_OPSEL: rd_mux = result_reg;
      CBM_OFF_FLAGS: rd_mux = {16'h0000, flags_reg};
      CBM_OFF_SAVE: rd_mux = {19'h0, save_total, 5'h00, save_n_reg};
      CBM_OFF_BROP: rd_mux = brop_reg;
      CBM_OFF_BRRES: rd_mux = brres;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Snapshot taken in the setup cycle; pready is then high in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata_reg <= rd_mux;
    end
  end

  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;
  assign apb_rsp.prdata = prdata_reg;

endmodule

`default_nettype wire

// ### shared/cbm_pkg.sv
// Package for the block-move execution unit: register map, fields, costs and carriers
`default_nettype none
package cbm_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CBM_OFF_CTRL = 8'h00;
  localparam logic [7:0] CBM_OFF_STATUS = 8'h04;
  localparam logic [7:0] CBM_OFF_SRC = 8'h08;
  localparam logic [7:0] CBM_OFF_DST = 8'h0c;
  localparam logic [7:0] CBM_OFF_COUNT = 8'h10;
  localparam logic [7:0] CBM_OFF_STATES = 8'h14;
  localparam logic [7:0] CBM_OFF_STALLS = 8'h18;
  localparam logic [7:0] CBM_OFF_OPA = 8'h1c;
  localparam logic [7:0] CBM_OFF_OPB = 8'h20;
  localparam logic [7:0] CBM_OFF_OPSEL = 8'h24;
  localparam logic [7:0] CBM_OFF_FLAGS = 8'h28;
  localparam logic [7:0] CBM_OFF_SAVE = 8'h2c;
  localparam logic [7:0] CBM_OFF_BROP = 8'h30;
  localparam logic [7:0] CBM_OFF_BRRES = 8'h34;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CBM_CTRL_START = 0;
  localparam int CBM_CTRL_WORD = 1;
  localparam int CBM_CTRL_EXT = 2;
  localparam int CBM_STAT_BUSY = 0;
  localparam int CBM_STAT_DONE = 1;
  localparam int CBM_FLG_C = 0;
  localparam int CBM_FLG_V = 1;
  localparam int CBM_FLG_Z = 2;
  localparam int CBM_FLG_N = 3;
  localparam int CBM_FLG_H = 5;
  localparam int CBM_FLG_DVN = 8;

  // ---------------------------------------------------------------
  // Reset values and state costs
  // ---------------------------------------------------------------
  localparam logic [31:0] CBM_RST_WORD = 32'h0000_0000;
  localparam logic [15:0] CBM_RST_FLAGS = 16'h0000;
  localparam logic [2:0] CBM_RST_SAVE = 3'h2;
  localparam logic [31:0] CBM_MOVE_BASE_STATES = 32'h0000_0004;
  localparam logic [31:0] CBM_MOVE_BYTE_STATES = 32'h0000_0002;
  localparam logic [4:0] CBM_SAVE2_STATES = 5'h07;
  localparam logic [4:0] CBM_SAVE3_STATES = 5'h09;
  localparam logic [4:0] CBM_SAVE4_STATES = 5'h0b;
  localparam logic [4:0] CBM_EXT_EXTRA = 5'h01;

  // ---------------------------------------------------------------
  // Branch encodings
  // ---------------------------------------------------------------
  localparam logic [3:0] CBM_BR_SHORT_HI = 4'h4;
  localparam logic [7:0] CBM_BR_LONG_OP = 8'h58;
  localparam logic [2:0] CBM_BR_SHORT_LEN = 3'h2;
  localparam logic [2:0] CBM_BR_LONG_LEN = 3'h4;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CBM_OP_ADDW = 3'b000,
    CBM_OP_SUBW = 3'b001,
    CBM_OP_ADDL = 3'b010,
    CBM_OP_SUBL = 3'b011,
    CBM_OP_ADDX = 3'b100,
    CBM_OP_SUBX = 3'b101,
    CBM_OP_DIVXS = 3'b110,
    CBM_OP_NONE = 3'b111
  } cbm_op_t;

  typedef enum logic [1:0] {
    CBM_ST_IDLE = 2'b00,
    CBM_ST_CHECK = 2'b01,
    CBM_ST_READ = 2'b10,
    CBM_ST_WRITE = 2'b11
  } cbm_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } cbm_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cbm_apb_rsp_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [7:0] wdata;
  } cbm_mem_req_t;

  typedef struct packed {
    logic ready;
    logic [7:0] rdata;
  } cbm_mem_rsp_t;

endpackage
`default_nettype wire

// ### verif/cbm_mem_model.sv
// On-chip memory model answering the block-move engine
`timescale 1ns/100ps
`default_nettype none
module cbm_mem_model (
  input wire logic pclk,
  input wire logic slow,
  input wire cbm_pkg::cbm_mem_req_t mem_req,
  output cbm_pkg::cbm_mem_rsp_t mem_rsp
);
  import cbm_pkg::*;
  // ----------------------------------------
  // Storage and wait states
  // ----------------------------------------
  logic [7:0] mem [1024];
  logic [1:0] wait_cnt = 2'h0;
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = (i < 256) ? 8'(i) ^ 8'h5a : 8'hee;
    end
  end
  always @(posedge pclk) begin
    if (mem_req.req && mem_rsp.ready) begin
      wait_cnt <= 2'h0;
    end else if (mem_req.req) begin
      wait_cnt <= wait_cnt + 2'h1;
    end
    if (mem_req.req && mem_rsp.ready && mem_req.we) begin
      mem[mem_req.addr[9:0]] <= mem_req.wdata;
    end
  end
  // Slow mode adds two wait states; stalls are not part of the ideal cost
  assign mem_rsp.ready = mem_req.req && (!slow || wait_cnt == 2'h2);
  // Data not yet valid shows the inverse so a early sample cannot pass
  assign mem_rsp.rdata = mem_rsp.ready ? mem[mem_req.addr[9:0]] : ~mem[mem_req.addr[9:0]];
endmodule
`default_nettype wire

// ### verif/cbm_exec_asserts.sv
// Port-level checks of the block-move engine
`timescale 1ns/100ps
`default_nettype none
module cbm_exec_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire cbm_pkg::cbm_apb_req_t apb_req,
  input wire cbm_pkg::cbm_apb_rsp_t apb_rsp,
  input wire cbm_pkg::cbm_mem_req_t mem_req,
  input wire cbm_pkg::cbm_mem_rsp_t mem_rsp
);
  import cbm_pkg::*;
  // ----------------------------------------
  // Mirror of the move count and of the last source and destination addresses
  // ----------------------------------------
  logic wr_en, start, rd_done, wr_done, zero_go, word_q, have_r, have_w;
  logic [15:0] cnt_q, left;
  logic [31:0] src_q, dst_q;
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign start = wr_en && apb_req.paddr == CBM_OFF_CTRL && apb_req.pwdata[CBM_CTRL_START];
  assign rd_done = mem_req.req && mem_rsp.ready && !mem_req.we;
  assign wr_done = mem_req.req && mem_rsp.ready && mem_req.we;
  assign left = word_q ? cnt_q : {8'h00, cnt_q[7:0]};
  assign zero_go = apb_req.pwdata[CBM_CTRL_WORD] ? cnt_q == 16'h0 : cnt_q[7:0] == 8'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
    end else if (wr_en && apb_req.paddr == CBM_OFF_COUNT) begin
      cnt_q <= apb_req.pwdata[15:0];
    end else if (wr_done) begin
      cnt_q <= word_q ? cnt_q - 16'h1 : {cnt_q[15:8], cnt_q[7:0] - 8'h1};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_q <= 1'b0;
    end else if (start) begin
      word_q <= apb_req.pwdata[CBM_CTRL_WORD];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      have_r <= 1'b0;
      have_w <= 1'b0;
      src_q <= 32'h0;
      dst_q <= 32'h0;
    end else if (!mem_req.req) begin
      have_r <= 1'b0;
      have_w <= 1'b0;
    end else if (rd_done) begin
      have_r <= 1'b1;
      src_q <= mem_req.addr;
    end else if (wr_done) begin
      have_w <= 1'b1;
      dst_q <= mem_req.addr;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_copy_byte:
    assert property (rd_done |=> mem_req.we && mem_req.wdata == $past(mem_rsp.rdata))
    else $error("written byte differs from read byte");
  a_read_first:
    assert property ($rose(mem_req.we) |-> $past(rd_done)) else $error("write without read");
  a_no_extra:
    assert property (rd_done |-> left != 16'h0) else $error("byte moved past count");
  a_stop_zero:
    assert property ($fell(mem_req.req) |-> left == 16'h0) else $error("move stopped early");
  a_src_step:
    assert property (rd_done && have_r |-> mem_req.addr == src_q + 32'h1)
    else $error("source not stepped by one");
  a_dst_step:
    assert property (wr_done && have_w |-> mem_req.addr == dst_q + 32'h1)
    else $error("destination not stepped by one");
  a_req_hold:
    assert property (mem_req.req && !mem_rsp.ready |=> mem_req.req && $stable(mem_req.addr))
    else $error("memory request dropped while waiting");
  a_zero_noop:
    assert property (start && zero_go |=> !mem_req.req [*4]) else $error("zero count moved");
  c_stall: cover property (mem_req.req && !mem_rsp.ready);
  c_zero: cover property (start && zero_go);
  c_end: cover property ($fell(mem_req.req));
endmodule
bind cbm_exec cbm_exec_asserts i_cbm_exec_asserts (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .mem_req(mem_req), .mem_rsp(mem_rsp));
`default_nettype wire

// ### verif/cbm_exec_tb.sv
// Self-checking bench for the block-move engine
`timescale 1ns/100ps
`default_nettype none
module cbm_exec_tb;
  import cbm_pkg::*;
  typedef struct packed {
    logic [2:0] op;
    logic [31:0] a;
    logic [31:0] b;
    logic [15:0] pre;
    logic [15:0] m;
    logic [15:0] e;
  } cbm_vec_t;
  localparam cbm_vec_t VEC [15] = '{
    '{CBM_OP_ADDW, 32'h0800, 32'h0800, 16'h0, 16'h20, 16'h20},
    '{CBM_OP_ADDW, 32'h07ff, 32'h0001, 16'h0, 16'h20, 16'h00},
    '{CBM_OP_SUBW, 32'h1000, 32'h0001, 16'h0, 16'h20, 16'h20},
    '{CBM_OP_SUBW, 32'h0fff, 32'h0001, 16'h0, 16'h20, 16'h00},
    '{CBM_OP_ADDL, 32'h0800_0000, 32'h0800_0000, 16'h0, 16'h20, 16'h20},
    '{CBM_OP_ADDL, 32'h0800, 32'h0800, 16'h0, 16'h20, 16'h00},
    '{CBM_OP_SUBL, 32'h1000_0000, 32'h1, 16'h0, 16'h20, 16'h20},
    '{CBM_OP_ADDX, 32'hff, 32'h01, 16'h4, 16'h4, 16'h4},
    '{CBM_OP_ADDX, 32'hff, 32'h01, 16'h0, 16'h4, 16'h0},
    '{CBM_OP_SUBX, 32'h05, 32'h04, 16'h4, 16'h4, 16'h0},
    '{CBM_OP_SUBX, 32'h04, 32'h04, 16'h4, 16'h4, 16'h4},
    '{CBM_OP_DIVXS, 32'h0010, 32'hfe, 16'h0, 16'h108, 16'h108},
    '{CBM_OP_DIVXS, 32'hfff0, 32'hfe, 16'h0, 16'h108, 16'h100},
    '{CBM_OP_DIVXS, 32'h0010, 32'h02, 16'h0, 16'h108, 16'h000},
    '{CBM_OP_DIVXS, 32'hfff0, 32'h02, 16'h0, 16'h108, 16'h008}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic slow = 1'b0;
  cbm_apb_req_t req = '0;
  cbm_apb_rsp_t rsp;
  cbm_mem_req_t mreq;
  cbm_mem_rsp_t mrsp;
  int failures = 0;
  int total_checks = 0;
  logic [31:0] q;
  logic err;
  localparam logic [15:0] TAKEN_N = 16'ha955;
  always #5 pclk = ~pclk;
  cbm_exec i_cbm_exec (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .mem_req(mreq), .mem_rsp(mrsp));
  cbm_mem_model i_cbm_mem_model (.pclk(pclk), .slow(slow), .mem_req(mreq), .mem_rsp(mrsp));
  // ----------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  // Runs one move from 0x000 to 0x200 and checks pointers, count, cost and memory
  task automatic move(input logic [31:0] ctl, input logic [15:0] cnt, input int n);
    int k;
    apb(1'b1, CBM_OFF_SRC, 32'h0);
    apb(1'b1, CBM_OFF_DST, 32'h200);
    apb(1'b1, CBM_OFF_COUNT, {16'h0, cnt});
    apb(1'b1, CBM_OFF_CTRL, ctl);
    k = 0;
    do begin
      apb(1'b0, CBM_OFF_STATUS, 32'h0);
      k++;
    end while (q[CBM_STAT_BUSY] !== 1'b0 && k < 2000);
    chk(q, 32'h2);
    rd(CBM_OFF_SRC, 32'hffff_ffff, 32'(n));
    rd(CBM_OFF_DST, 32'hffff_ffff, 32'h200 + 32'(n));
    rd(CBM_OFF_COUNT, 32'hffff, ctl[1] ? 32'h0 : {16'h0, cnt & 16'hff00});
    rd(CBM_OFF_STATES, 32'hffff_ffff, 32'h4 + 32'(2 * n));
    for (int i = 0; i <= n; i++) begin
      chk(32'(i_cbm_mem_model.mem[512 + i]), (i < n && i < 256) ? 8'(i) ^ 8'h5a : 8'hee);
    end
  endtask
  task automatic results;
    if (failures == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #300000;
    failures++;
    results();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(CBM_OFF_STATUS, 32'hffff_ffff, 32'h0);
    rd(CBM_OFF_SAVE, 32'hffff_ffff, 32'h0702);
    rd(8'h38, 32'hffff_ffff, 32'h0);
    chk({31'h0, err}, 32'h1);
    move(32'h1, 16'h0100, 0);
    slow <= 1'b1;
    move(32'h1, 16'h0103, 3);
    rd(CBM_OFF_STALLS, 32'hffff_ffff, 32'hc);
    slow <= 1'b0;
    move(32'h3, 16'h0101, 257);
    for (int x = 0; x < 2; x++) begin
      apb(1'b1, CBM_OFF_CTRL, 32'(x) << CBM_CTRL_EXT);
      for (int k = 1; k < 5; k++) begin
        apb(1'b1, CBM_OFF_SAVE, 32'(k));
        rd(CBM_OFF_SAVE, 32'h3f07, {18'h0, (k > 1) ? 6'(2 * k + 3 + x) : 6'h0, 8'(k)});
      end
    end
    foreach (VEC[i]) begin
      apb(1'b1, CBM_OFF_FLAGS, {16'h0, VEC[i].pre});
      apb(1'b1, CBM_OFF_OPA, VEC[i].a);
      apb(1'b1, CBM_OFF_OPB, VEC[i].b);
      apb(1'b1, CBM_OFF_OPSEL, {29'h0, VEC[i].op});
      rd(CBM_OFF_FLAGS, {16'h0, VEC[i].m}, {16'h0, VEC[i].e});
    end
    apb(1'b1, CBM_OFF_FLAGS, 32'h8);
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, CBM_OFF_BROP, {4'h4, 4'(c), 24'h80_0000});
      rd(CBM_OFF_BRRES, 32'hffff_03f7, {16'hff80, 7'h1, TAKEN_N[c], 4'(c), 4'h2});
      apb(1'b1, CBM_OFF_BROP, {8'h58, 4'(c), 4'h0, 16'h1234});
      rd(CBM_OFF_BRRES, 32'hffff_03f7, {16'h1234, 7'h1, TAKEN_N[c], 4'(c), 4'h4});
    end
    apb(1'b1, CBM_OFF_BROP, 32'h0);
    rd(CBM_OFF_BRRES, 32'h0207, 32'h0);
    results();
  end
endmodule
`default_nettype wire
